/* File: hw/bgcr_pkg.sv */
// bgcr_pkg: constants and carrier types of the global buck configuration bank
// assumes: byte-wide register port behind the serial control decoder
package bgcr_pkg;
  // register addresses
  localparam logic [7:0] BGCR_ADDR_SLEW_SS = 8'h33;
  localparam logic [7:0] BGCR_ADDR_SLEW_RAMP = 8'h34;
  localparam logic [7:0] BGCR_ADDR_PROT = 8'h35;
  localparam logic [7:0] BGCR_ADDR_RSVD_LO = 8'h36;
  // reset values
  localparam logic [7:0] BGCR_RST_SLEW_SS = 8'h24;
  localparam logic [7:0] BGCR_RST_SLEW_RAMP = 8'h24;
  localparam logic [7:0] BGCR_RST_PROT = 8'h5f;
  // writable bits; bits 7 and 3 of the slew registers are reserved
  localparam logic [7:0] BGCR_SLEW_MASK = 8'h77;
  // field positions
  localparam int BGCR_HI_CODE_LSB = 4;
  localparam int BGCR_LO_CODE_LSB = 0;
  localparam int BGCR_BIT_ILIM_OFF = 7;
  localparam int BGCR_BIT_AZX = 6;
  localparam int BGCR_BIT_SHARE_WIDE = 5;
  localparam int BGCR_BIT_SHARE_EN = 4;
  localparam int BGCR_BIT_BRAKE = 3;
  localparam int BGCR_BIT_NMASK_LONG = 2;
  localparam int BGCR_BIT_PBOOST = 1;
  localparam int BGCR_BIT_NBOOST = 0;
  // negative boost mask lengths in minimum on-time clocks
  localparam logic [3:0] BGCR_NMASK_SHORT = 4'h2;
  localparam logic [3:0] BGCR_NMASK_LONG = 4'h8;
  // forced switching hold after ramp-down target
  localparam int BGCR_FS_HOLD_US = 50;
  localparam int BGCR_CLK_MHZ = 100;
  localparam int BGCR_FS_HOLD_CYC = BGCR_FS_HOLD_US * BGCR_CLK_MHZ;
  // slew rates as multiples of 1.25 mV/us
  localparam logic [5:0] BGCR_RATE_1P25 = 6'h01;
  localparam logic [5:0] BGCR_RATE_2P5 = 6'h02;
  localparam logic [5:0] BGCR_RATE_5 = 6'h04;
  localparam logic [5:0] BGCR_RATE_10 = 6'h08;
  localparam logic [5:0] BGCR_RATE_20 = 6'h10;
  localparam logic [5:0] BGCR_RATE_40 = 6'h20;
  localparam logic [5:0] BGCR_RATE_60 = 6'h30;
  localparam logic [5:0] BGCR_RATE_NONE = 6'h00;

  // decoded configuration seen by the analog control
  typedef struct packed {
    logic [2:0] shutdown_slew_code;
    logic [2:0] soft_start_slew_code;
    logic [2:0] ramp_down_slew_code;
    logic [2:0] ramp_up_slew_code;
    logic [5:0] shutdown_rate;
    logic [5:0] soft_start_rate;
    logic [5:0] ramp_down_rate;
    logic [5:0] ramp_up_rate;
    logic current_limit_disable;
    logic adaptive_zero_cross_enable;
    logic share_range_wide;
    logic share_enable;
    logic body_brake_enable;
    logic negative_boost_mask_len;
    logic positive_boost_enable;
    logic negative_boost_enable;
  } bgcr_cfg_type;
endpackage : bgcr_pkg

/* File: hw/bgcr_hold_timer.sv */
// bgcr_hold_timer: loadable down counter that reports busy while nonzero
// assumes: start wins over clear and tick; synchronous high reset
`timescale 1ns/100ps
`default_nettype none
module bgcr_hold_timer #(
  parameter int W = 4
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [W-1:0] load_i,
  input wire logic tick_i,
  input wire logic clear_i,
  output logic busy_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // next count
  always_comb
  begin
    cnt_d = cnt_q;
    if (start_i)
    begin
      cnt_d = load_i;
    end
    else if (clear_i)
    begin
      cnt_d = '0;
    end
    else if (tick_i && cnt_q != '0)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // count register
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_o = (cnt_q != '0);
endmodule : bgcr_hold_timer
`default_nettype wire

/* File: hw/bgcr_regs.sv */
// bgcr_regs: global slew, protection and transient configuration bank
// assumes: serial port decoder gives one-cycle byte read/write strobes
// How it works
// - first register bits 6:4 pick shutdown slew, 111b is 60, reset 010b
// - first register bits 2:0 pick soft-start slew up to 60, reset 100b
// - second register bits 6:4 pick ramp-down slew like shutdown, reset 010b
// - second register bits 2:0 pick ramp-up slew, 110b and 111b give 60
// - third register bit 7 high disables current limits, reset 0
// - third register bit 6 enables adaptive zero crossing, reset 1
// - third register bit 5 selects wide sharing range, reset 0
// - third register bit 4 enables current sharing, reset 1
// - third register bit 3 enables body braking during positive boost, reset 1
// - after negative boost, mask further ones 2 or 8 on-time clocks
// - bit 1 enables positive boost, bit 0 negative boost, both reset 1
// - addresses 0x36 to 0xff are reserved, no function
// - falling-slew control forces continuous switching during ramp-down
// - forced switching holds 50 us after target is reached
`timescale 1ns/100ps
`default_nettype none
module bgcr_regs
  import bgcr_pkg::*;
#(
  parameter int FS_HOLD_CYC = BGCR_FS_HOLD_CYC,
  parameter int FS_W = 13
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic negative_transient_boost_i,
  input wire logic positive_transient_boost_i,
  input wire logic minimum_on_time_signal_i,
  input wire logic falling_slew_control_enable_i,
  input wire logic ramp_down_active_i,
  input wire logic target_reached_i,
  output bgcr_cfg_type cfg_o,
  output logic negative_boost_fire_o,
  output logic positive_boost_fire_o,
  output logic body_brake_o,
  output logic negative_boost_masked_o,
  output logic forced_switching_o
);
  logic [7:0] slew_ss_q;
  logic [7:0] slew_ss_d;
  logic [7:0] slew_ramp_q;
  logic [7:0] slew_ramp_d;
  logic [7:0] prot_q;
  logic [7:0] prot_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic nb_fire;
  logic fs_start;

  // write path; reserved space ignores writes
  always_comb
  begin
    slew_ss_d = slew_ss_q;
    slew_ramp_d = slew_ramp_q;
    prot_d = prot_q;
    if (reg_wr_i)
    begin
      if (reg_addr_i == BGCR_ADDR_SLEW_SS)
      begin
        slew_ss_d = reg_wdata_i & BGCR_SLEW_MASK;
      end
      else if (reg_addr_i == BGCR_ADDR_SLEW_RAMP)
      begin
        slew_ramp_d = reg_wdata_i & BGCR_SLEW_MASK;
      end
      else if (reg_addr_i == BGCR_ADDR_PROT)
      begin
        prot_d = reg_wdata_i;
      end
    end
  end

  // read path, data one cycle after the strobe
  always_comb
  begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd_i;
    if (reg_rd_i)
    begin
      if (reg_addr_i == BGCR_ADDR_SLEW_SS)
      begin
        rdata_d = slew_ss_q;
      end
      else if (reg_addr_i == BGCR_ADDR_SLEW_RAMP)
      begin
        rdata_d = slew_ramp_q;
      end
      else if (reg_addr_i == BGCR_ADDR_PROT)
      begin
        rdata_d = prot_q;
      end
      else
      begin
        rdata_d = 8'h00;
      end
    end
  end

  // register bank
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      slew_ss_q <= BGCR_RST_SLEW_SS;
      slew_ramp_q <= BGCR_RST_SLEW_RAMP;
      prot_q <= BGCR_RST_PROT;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      slew_ss_q <= slew_ss_d;
      slew_ramp_q <= slew_ramp_d;
      prot_q <= prot_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // code to rate; shutdown-style fields give 60 at 111b only
  function automatic logic [5:0] rate_of(input logic [2:0] code, input logic six_is_60);
    logic [5:0] r;
    r = BGCR_RATE_NONE;
    case (code)
      3'h0: r = BGCR_RATE_1P25;
      3'h1: r = BGCR_RATE_2P5;
      3'h2: r = BGCR_RATE_5;
      3'h3: r = BGCR_RATE_10;
      3'h4: r = BGCR_RATE_20;
      3'h5: r = BGCR_RATE_40;
      3'h6: r = six_is_60 ? BGCR_RATE_60 : BGCR_RATE_NONE;
      default: r = BGCR_RATE_60;
    endcase
    return r;
  endfunction : rate_of

  // field decode
  always_comb
  begin
    cfg_o.shutdown_slew_code = slew_ss_q[BGCR_HI_CODE_LSB +: 3];
    cfg_o.soft_start_slew_code = slew_ss_q[BGCR_LO_CODE_LSB +: 3];
    cfg_o.ramp_down_slew_code = slew_ramp_q[BGCR_HI_CODE_LSB +: 3];
    cfg_o.ramp_up_slew_code = slew_ramp_q[BGCR_LO_CODE_LSB +: 3];
    cfg_o.shutdown_rate = rate_of(cfg_o.shutdown_slew_code, 1'b0);
    cfg_o.soft_start_rate = rate_of(cfg_o.soft_start_slew_code, 1'b1);
    cfg_o.ramp_down_rate = rate_of(cfg_o.ramp_down_slew_code, 1'b0);
    cfg_o.ramp_up_rate = rate_of(cfg_o.ramp_up_slew_code, 1'b1);
    cfg_o.current_limit_disable = prot_q[BGCR_BIT_ILIM_OFF];
    cfg_o.adaptive_zero_cross_enable = prot_q[BGCR_BIT_AZX];
    cfg_o.share_range_wide = prot_q[BGCR_BIT_SHARE_WIDE];
    cfg_o.share_enable = prot_q[BGCR_BIT_SHARE_EN];
    cfg_o.body_brake_enable = prot_q[BGCR_BIT_BRAKE];
    cfg_o.negative_boost_mask_len = prot_q[BGCR_BIT_NMASK_LONG];
    cfg_o.positive_boost_enable = prot_q[BGCR_BIT_PBOOST];
    cfg_o.negative_boost_enable = prot_q[BGCR_BIT_NBOOST];
  end

  // transient boost gating and braking
  assign positive_boost_fire_o = positive_transient_boost_i & prot_q[BGCR_BIT_PBOOST];
  assign body_brake_o = positive_boost_fire_o & prot_q[BGCR_BIT_BRAKE];
  assign nb_fire = negative_transient_boost_i & prot_q[BGCR_BIT_NBOOST]
                   & ~negative_boost_masked_o;
  assign negative_boost_fire_o = nb_fire;

  // negative boost mask window in on-time clocks
  bgcr_hold_timer #(.W(4)) u_nmask (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .start_i(nb_fire),
    .load_i(prot_q[BGCR_BIT_NMASK_LONG] ? BGCR_NMASK_LONG : BGCR_NMASK_SHORT),
    .tick_i(minimum_on_time_signal_i),
    .clear_i(1'b0),
    .busy_o(negative_boost_masked_o)
  );

  // checker helper: top bit keeps the mask length, low bits count ticks since a fire
  logic [4:0] nm_seen_q;
  logic [4:0] nm_seen_d;
  always_comb
  begin
    nm_seen_d = nm_seen_q;
    if (nb_fire)
    begin
      nm_seen_d = {prot_q[BGCR_BIT_NMASK_LONG], 4'h0};
    end
    else if (minimum_on_time_signal_i && nm_seen_q[3:0] != 4'hf)
    begin
      nm_seen_d = nm_seen_q + 5'h01;
    end
  end
  // helper register, saturated after reset so no mask is expected
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      nm_seen_q <= 5'h0f;
    end
    else
    begin
      nm_seen_q <= nm_seen_d;
    end
  end

  // forced switching hold after ramp-down reaches target
  assign fs_start = falling_slew_control_enable_i & target_reached_i;
  logic fs_hold;
  bgcr_hold_timer #(.W(FS_W)) u_fshold (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .start_i(fs_start),
    .load_i(FS_W'(FS_HOLD_CYC)),
    .tick_i(1'b1),
    .clear_i(~falling_slew_control_enable_i),
    .busy_o(fs_hold)
  );
  assign forced_switching_o = falling_slew_control_enable_i
                              & (ramp_down_active_i | fs_hold);

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // checks
  property p_slew_reserved_zero;
    @(posedge ref_clk_i) disable iff (srst_i)
      (slew_ss_q[7] == 1'b0) && (slew_ss_q[3] == 1'b0)
      && (slew_ramp_q[7] == 1'b0) && (slew_ramp_q[3] == 1'b0);
  endproperty
  a_slew_reserved_zero: assert property (p_slew_reserved_zero)
    else $error("reserved slew bit set");

  property p_rsvd_reads_zero;
    @(posedge ref_clk_i) disable iff (srst_i)
      reg_rd_i && reg_addr_i >= BGCR_ADDR_RSVD_LO |=> reg_rvalid_o && reg_rdata_o == 8'h00;
  endproperty
  a_rsvd_reads_zero: assert property (p_rsvd_reads_zero) else $error("rsvd not zero");

  property p_prot_write_read;
    @(posedge ref_clk_i) disable iff (srst_i)
      reg_wr_i && reg_addr_i == BGCR_ADDR_PROT ##1 reg_rd_i && reg_addr_i == BGCR_ADDR_PROT
      && !reg_wr_i |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_prot_write_read: assert property (p_prot_write_read) else $error("prot readback");

  property p_reset_values;
    @(posedge ref_clk_i) $fell(srst_i) |-> slew_ss_q == 8'h24 && slew_ramp_q == 8'h24
      && prot_q == 8'h5f;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_shutdown_111;
    @(posedge ref_clk_i) disable iff (srst_i)
      cfg_o.shutdown_slew_code == 3'h7 |-> cfg_o.shutdown_rate == 6'h30;
  endproperty
  a_shutdown_111: assert property (p_shutdown_111) else $error("shutdown 111b rate");

  property p_ramp_up_60;
    @(posedge ref_clk_i) disable iff (srst_i)
      cfg_o.ramp_up_slew_code[2:1] == 2'b11 |-> cfg_o.ramp_up_rate == 6'h30;
  endproperty
  a_ramp_up_60: assert property (p_ramp_up_60) else $error("ramp-up top not 60");

  property p_nmask_len;
    @(posedge ref_clk_i) disable iff (srst_i)
      negative_boost_masked_o
      == (nm_seen_q[3:0] < (nm_seen_q[4] ? BGCR_NMASK_LONG : BGCR_NMASK_SHORT));
  endproperty
  a_nmask_len: assert property (p_nmask_len) else $error("mask length wrong");

  property p_nmask_blocks;
    @(posedge ref_clk_i) disable iff (srst_i)
      negative_boost_masked_o |-> !negative_boost_fire_o;
  endproperty
  a_nmask_blocks: assert property (p_nmask_blocks) else $error("fired while masked");

  property p_fs_hold;
    @(posedge ref_clk_i) disable iff (srst_i)
      fs_start |=> forced_switching_o [*8];
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("forced hold dropped early");

  property p_brake_needs_boost;
    @(posedge ref_clk_i) disable iff (srst_i)
      body_brake_o |-> positive_transient_boost_i && prot_q[BGCR_BIT_PBOOST];
  endproperty
  a_brake_needs_boost: assert property (p_brake_needs_boost) else $error("no boost");
endmodule : bgcr_regs
`default_nettype wire

/* File: sim/bgcr_regs_tb.sv */
// bgcr_regs_tb: self-checking bench for the global configuration bank
// assumes: bgcr_pkg compiled first; forced hold shortened to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module bgcr_regs_tb
  import bgcr_pkg::*;
;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic nev = 1'b0;
  logic pev = 1'b0;
  logic tick = 1'b0;
  logic fs_en = 1'b0;
  logic ramp = 1'b0;
  logic tgt = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  bgcr_cfg_type cfg;
  logic nfire;
  logic pfire;
  logic brake;
  logic nmasked;
  logic forced;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] p;
  logic [7:0] a;

  bgcr_regs #(.FS_HOLD_CYC(HOLD)) u_dut (.ref_clk_i(clk), .srst_i(srst), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .negative_transient_boost_i(nev), .positive_transient_boost_i(pev),
    .minimum_on_time_signal_i(tick), .falling_slew_control_enable_i(fs_en),
    .ramp_down_active_i(ramp), .target_reached_i(tgt), .cfg_o(cfg),
    .negative_boost_fire_o(nfire), .positive_boost_fire_o(pfire), .body_brake_o(brake),
    .negative_boost_masked_o(nmasked), .forced_switching_o(forced));

  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  // rate expected for a slew code; gap marks 110b as undefined
  function automatic logic [7:0] rate_of(input logic [2:0] c, input logic gap);
    case (c)
      3'h0: return 8'h01;
      3'h1: return 8'h02;
      3'h2: return 8'h04;
      3'h3: return 8'h08;
      3'h4: return 8'h10;
      3'h5: return 8'h20;
      3'h6: return gap ? 8'h00 : 8'h30;
      default: return 8'h30;
    endcase
  endfunction : rate_of

  task automatic stop_test();
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic reg_wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_bit("rvalid", 1'b1, rvalid);
    chk_byte("rdata", e, rdata);
  endtask : reg_rd

  // write then read back in the very next cycle
  task automatic reg_wr_rd(input logic [7:0] ad, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_bit("rvalid", 1'b1, rvalid);
    chk_byte("rdata", e, rdata);
  endtask : reg_wr_rd

  // decoded fields against written register images
  task automatic chk_cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
    chk_byte("sd_code", {5'h0, c1[6:4]}, {5'h0, cfg.shutdown_slew_code});
    chk_byte("sd_rate", rate_of(c1[6:4], 1'b1), {2'h0, cfg.shutdown_rate});
    chk_byte("ss_code", {5'h0, c1[2:0]}, {5'h0, cfg.soft_start_slew_code});
    if (c1[2:0] != 3'h7)
      chk_byte("ss_rate", rate_of(c1[2:0], 1'b0), {2'h0, cfg.soft_start_rate});
    chk_byte("rd_code", {5'h0, c2[6:4]}, {5'h0, cfg.ramp_down_slew_code});
    chk_byte("rd_rate", rate_of(c2[6:4], 1'b1), {2'h0, cfg.ramp_down_rate});
    chk_byte("ru_code", {5'h0, c2[2:0]}, {5'h0, cfg.ramp_up_slew_code});
    chk_byte("ru_rate", rate_of(c2[2:0], 1'b0), {2'h0, cfg.ramp_up_rate});
    chk_byte("flags", c3, {cfg.current_limit_disable, cfg.adaptive_zero_cross_enable,
      cfg.share_range_wide, cfg.share_enable, cfg.body_brake_enable,
      cfg.negative_boost_mask_len, cfg.positive_boost_enable,
      cfg.negative_boost_enable});
  endtask : chk_cfg

  // negative boost event, then counted mask release
  task automatic nmask(input logic lng, input int len);
    reg_wr(8'h35, lng ? 8'h5f : 8'h5b);
    @(posedge clk);
    nev <= 1'b1;
    #1;
    chk_bit("nfire", 1'b1, nfire);
    @(posedge clk);
    #1;
    chk_bit("nmasked", 1'b1, nmasked);
    chk_bit("nfire_masked", 1'b0, nfire);
    @(posedge clk);
    nev <= 1'b0;
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      #1;
      chk_bit("mask_len", i < len - 1, nmasked);
    end
  endtask : nmask

  // cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      stop_test();
    end
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h051b99be));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    reg_rd(8'h33, 8'h24);
    reg_rd(8'h34, 8'h24);
    reg_rd(8'h35, 8'h5f);
    chk_cfg(8'h24, 8'h24, 8'h5f);
    // every code first with reserved bits set, then random images
    for (int i = 0; i < 28; i++)
    begin
      s1 = (i < 8) ? {1'b1, i[2:0], 1'b1, ~i[2:0]} : 8'($urandom);
      s2 = (i < 8) ? {1'b1, ~i[2:0], 1'b1, i[2:0]} : 8'($urandom);
      p = 8'($urandom);
      reg_wr(8'h33, s1);
      reg_wr(8'h34, s2);
      reg_rd(8'h33, s1 & 8'h77);
      reg_rd(8'h34, s2 & 8'h77);
      reg_wr_rd(8'h35, p, p);
      chk_cfg(s1 & 8'h77, s2 & 8'h77, p);
      @(posedge clk);
      pev <= 1'b1;
      #1;
      chk_bit("pfire", p[1], pfire);
      chk_bit("brake", p[1] & p[3], brake);
      @(posedge clk);
      pev <= 1'b0;
    end
    // reserved addresses hold nothing and disturb nothing
    for (int i = 0; i < 3; i++)
    begin
      a = (i == 0) ? 8'h36 : (i == 1) ? 8'hff : 8'h37 + 8'($urandom_range(199));
      reg_wr(a, 8'hff);
      reg_rd(a, 8'h00);
      reg_rd(8'h35, p);
    end
    nmask(1'b0, 2);
    nmask(1'b1, 8);
    // forced switching through ramp-down and the hold after target
    @(posedge clk);
    fs_en <= 1'b1;
    ramp <= 1'b1;
    @(posedge clk);
    #1;
    chk_bit("forced_ramp", 1'b1, forced);
    @(posedge clk);
    tgt <= 1'b1;
    @(posedge clk);
    tgt <= 1'b0;
    ramp <= 1'b0;
    n = 0;
    // count from the load edge on; the hold covers exactly HOLD cycles
    repeat (HOLD + 4)
    begin
      #1;
      n = n + int'(forced);
      @(posedge clk);
    end
    chk_byte("hold_len", 8'(HOLD), 8'(n));
    @(posedge clk);
    fs_en <= 1'b0;
    ramp <= 1'b1;
    #1;
    chk_bit("forced_off", 1'b0, forced);
    @(posedge clk);
    ramp <= 1'b0;
    // negative boost disabled: no fire and no mask
    reg_wr(8'h35, 8'h5e);
    @(posedge clk);
    nev <= 1'b1;
    #1;
    chk_bit("nfire_off", 1'b0, nfire);
    @(posedge clk);
    nev <= 1'b0;
    #1;
    chk_bit("nmask_off", 1'b0, nmasked);
    // reset in mid-run brings back the reset images
    reg_wr(8'h33, 8'h11);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    reg_rd(8'h33, 8'h24);
    reg_rd(8'h35, 8'h5f);
    stop_test();
  end
endmodule : bgcr_regs_tb
`default_nettype wire
